// file: pkg/pcp_pkg.sv
// constants for the phy configuration and status pin block
// assumes one clock domain and a 32-bit axi4-lite register bus
package pcp_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] PCP_OFF_CTRL = 4'h0;
  localparam logic [3:0] PCP_OFF_STATUS = 4'h4;
  localparam logic [3:0] PCP_OFF_INT_STAT = 4'h8;
  localparam logic [3:0] PCP_OFF_INT_MASK = 4'hc;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int PCP_CTRL_SPEED_BIT = 0;
  localparam int PCP_CTRL_LOWPWR_BIT = 1;
  localparam logic [1:0] PCP_CTRL_RST = 2'h1;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int PCP_ST_SWMODE_BIT = 0;
  localparam int PCP_ST_REPEATER_BIT = 1;
  localparam int PCP_ST_IFACE_LSB = 2;
  localparam int PCP_ST_SPEED_BIT = 4;
  localparam int PCP_ST_LOWPWR_BIT = 5;
  localparam int PCP_ST_LOCK_BIT = 6;
  localparam int PCP_ST_LINK_BIT = 7;
  localparam int PCP_ST_SIGDET_BIT = 8;
  localparam int PCP_ST_RUN_BIT = 9;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int PCP_INT_W = 3;
  localparam int PCP_INT_LOCK_BIT = 0;
  localparam int PCP_INT_LINK_BIT = 1;
  localparam int PCP_INT_SIGDET_BIT = 2;

  // ----------------------------------------------------------------
  // bus answers and synchroniser width
  // ----------------------------------------------------------------
  localparam logic [1:0] PCP_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCP_RESP_SLVERR = 2'h2;
  localparam int PCP_SYNC_W = 6;

  // ----------------------------------------------------------------
  // mac-side interface kinds and bring-up states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCP_IF_MII = 2'h0,
    PCP_IF_SYMBOL100 = 2'h1,
    PCP_IF_SERIAL10 = 2'h2
  } pcp_iface_type;

  typedef enum logic [1:0] {
    PCP_ST_HOLD = 2'h0,
    PCP_ST_SAMPLE = 2'h1,
    PCP_ST_RUN = 2'h3
  } pcp_state_type;

endpackage

// file: rtl/pcp_config_status.sv
// configuration decode and status pin drive for a 10/100 phy
// assumes strap pins are quasi-static, core status inputs synchronous
// to clk, and an axi4-lite master on the register port
//
// Contract
// - low control select hardware, high software mode
// - software mode drives config pins as outputs
// - lock output high while descrambler locked
// - link output high while link established
// - link pin carries signal detect in stream modes
// - interface select low mii, high stream
// - interface type uses speed and low-power too
// - role select low node, high repeater default
// - role changes sqe test and carrier sense
// - reset pin low holds core in reset
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module pcp_config_status #(
  parameter int ADDR_W = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // board pins
  input wire logic hard_reset_low,
  input wire logic control_source_select,
  input wire logic station_role_select,
  input wire logic mii_stream_select,
  input wire logic speed_select_in,
  output logic speed_select_out,
  output logic speed_select_oe,
  input wire logic low_power_ten_select_in,
  output logic low_power_ten_select_out,
  output logic low_power_ten_select_oe,
  output logic cipher_lock_out,
  output logic link_up_out,
  output logic carrier_sense_out,
  // core side
  input wire logic descrambler_locked,
  input wire logic link_established,
  input wire logic signal_detected,
  input wire logic rx_activity,
  input wire logic tx_activity,
  output logic core_reset,
  output logic sqe_test_enable,
  output logic speed_100,
  output logic [1:0] iface_mode,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [pcp_pkg::PCP_SYNC_W-1:0] sync1_q;
  logic [pcp_pkg::PCP_SYNC_W-1:0] sync2_q;
  pcp_pkg::pcp_state_type state_q;
  pcp_pkg::pcp_state_type state_d;
  logic sw_mode_q;
  logic repeater_q;
  logic stream_q;
  logic hw_speed_q;
  logic hw_lowpwr_q;
  logic [1:0] ctrl_q;
  logic eff_speed;
  logic eff_lowpwr;
  pcp_pkg::pcp_iface_type iface;
  logic running;
  logic lock_q;
  logic link_q;
  logic sigdet_q;
  logic [pcp_pkg::PCP_INT_W-1:0] events;
  logic [pcp_pkg::PCP_INT_W-1:0] int_stat_q;
  logic [pcp_pkg::PCP_INT_W-1:0] int_mask_q;
  logic [pcp_pkg::PCP_INT_W-1:0] int_clr;
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic do_write;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_ok;

  // ----------------------------------------------------------------
  // pin synchroniser, first stage read only by second
  // ----------------------------------------------------------------
  // two flops per pin; straps are slow so skew between bits is harmless
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= {hard_reset_low, control_source_select,
                  station_role_select, mii_stream_select,
                  speed_select_in, low_power_ten_select_in};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // bring-up sequence
  // ----------------------------------------------------------------
  // hold while reset pin low, sample straps once, then run
  always_comb begin
    state_d = state_q;
    case (state_q)
      pcp_pkg::PCP_ST_HOLD: begin
        if (sync2_q[5]) begin
          state_d = pcp_pkg::PCP_ST_SAMPLE;
        end
      end
      pcp_pkg::PCP_ST_SAMPLE: begin
        state_d = sync2_q[5] ? pcp_pkg::PCP_ST_RUN : pcp_pkg::PCP_ST_HOLD;
      end
      pcp_pkg::PCP_ST_RUN: begin
        if (!sync2_q[5]) begin
          state_d = pcp_pkg::PCP_ST_HOLD;
        end
      end
      default: begin
        state_d = pcp_pkg::PCP_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= pcp_pkg::PCP_ST_HOLD;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign running = (state_q == pcp_pkg::PCP_ST_RUN);
  assign core_reset = !running;

  // ----------------------------------------------------------------
  // strap capture at reset release
  // ----------------------------------------------------------------
  // straps latched once so modes stay consistent until next reset
  always_ff @(posedge clk) begin
    if (reset) begin
      sw_mode_q <= 1'b0;
      repeater_q <= 1'b0;
      stream_q <= 1'b0;
      hw_speed_q <= 1'b0;
      hw_lowpwr_q <= 1'b0;
    end else if (ce && state_q == pcp_pkg::PCP_ST_SAMPLE) begin
      sw_mode_q <= sync2_q[4];
      repeater_q <= sync2_q[3];
      stream_q <= sync2_q[2];
      hw_speed_q <= sync2_q[1];
      hw_lowpwr_q <= sync2_q[0];
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // software mode takes speed and low power from the control register
  assign eff_speed = sw_mode_q ? ctrl_q[pcp_pkg::PCP_CTRL_SPEED_BIT]
                               : hw_speed_q;
  assign eff_lowpwr = sw_mode_q ? ctrl_q[pcp_pkg::PCP_CTRL_LOWPWR_BIT]
                                : hw_lowpwr_q;

  // stream mode splits by speed and low-power select
  always_comb begin
    if (!stream_q) begin
      iface = pcp_pkg::PCP_IF_MII;
    end else if (eff_speed && !eff_lowpwr) begin
      iface = pcp_pkg::PCP_IF_SYMBOL100;
    end else begin
      iface = pcp_pkg::PCP_IF_SERIAL10;
    end
  end

  // ----------------------------------------------------------------
  // pin and core outputs
  // ----------------------------------------------------------------
  // registered so no glitch reaches the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      speed_select_out <= 1'b0;
      speed_select_oe <= 1'b0;
      low_power_ten_select_out <= 1'b0;
      low_power_ten_select_oe <= 1'b0;
      cipher_lock_out <= 1'b0;
      link_up_out <= 1'b0;
      carrier_sense_out <= 1'b0;
      sqe_test_enable <= 1'b0;
      speed_100 <= 1'b0;
      iface_mode <= pcp_pkg::PCP_IF_MII;
    end else if (ce) begin
      // config pins turn to outputs only in software mode
      speed_select_out <= eff_speed;
      speed_select_oe <= running && sw_mode_q;
      low_power_ten_select_out <= eff_lowpwr;
      low_power_ten_select_oe <= running && sw_mode_q;
      cipher_lock_out <= running && descrambler_locked;
      if (iface == pcp_pkg::PCP_IF_MII) begin
        link_up_out <= running && link_established;
      end else begin
        link_up_out <= running && signal_detected;
      end
      // repeater sees receive only; node also counts its own transmit
      carrier_sense_out <= running && (rx_activity ||
                           (!repeater_q && tx_activity));
      sqe_test_enable <= running && !repeater_q;
      speed_100 <= eff_speed;
      iface_mode <= iface;
    end
  end

  // ----------------------------------------------------------------
  // status tracking and interrupt events
  // ----------------------------------------------------------------
  // an event is any change of lock, link or signal detect
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_q <= 1'b0;
      link_q <= 1'b0;
      sigdet_q <= 1'b0;
    end else if (ce) begin
      lock_q <= running && descrambler_locked;
      link_q <= running && link_established;
      sigdet_q <= running && signal_detected;
    end
  end

  always_comb begin
    events = '0;
    events[pcp_pkg::PCP_INT_LOCK_BIT] =
      lock_q != (running && descrambler_locked);
    events[pcp_pkg::PCP_INT_LINK_BIT] =
      link_q != (running && link_established);
    events[pcp_pkg::PCP_INT_SIGDET_BIT] =
      sigdet_q != (running && signal_detected);
  end

  // write one clears; a new event in the same cycle wins
  assign int_clr = (do_write && awaddr_q == pcp_pkg::PCP_OFF_INT_STAT
                    && wstrb0_q) ? wdata_q[pcp_pkg::PCP_INT_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (reset) begin
      int_stat_q <= '0;
    end else if (ce) begin
      int_stat_q <= (int_stat_q & ~int_clr) | events;
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  // address and data taken in either order, answer after both
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcp_pkg::PCP_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == pcp_pkg::PCP_OFF_CTRL ||
            awaddr_q == pcp_pkg::PCP_OFF_STATUS ||
            awaddr_q == pcp_pkg::PCP_OFF_INT_STAT ||
            awaddr_q == pcp_pkg::PCP_OFF_INT_MASK) begin
          s_axi_bresp <= pcp_pkg::PCP_RESP_OKAY;
        end else begin
          s_axi_bresp <= pcp_pkg::PCP_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable registers; status is read only and ignores writes
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= pcp_pkg::PCP_CTRL_RST;
      int_mask_q <= '0;
    end else if (ce && do_write && wstrb0_q) begin
      if (awaddr_q == pcp_pkg::PCP_OFF_CTRL) begin
        ctrl_q <= wdata_q[1:0];
      end else if (awaddr_q == pcp_pkg::PCP_OFF_INT_MASK) begin
        int_mask_q <= wdata_q[pcp_pkg::PCP_INT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[pcp_pkg::PCP_ST_SWMODE_BIT] = sw_mode_q;
    status_word[pcp_pkg::PCP_ST_REPEATER_BIT] = repeater_q;
    status_word[pcp_pkg::PCP_ST_IFACE_LSB +: 2] = iface;
    status_word[pcp_pkg::PCP_ST_SPEED_BIT] = eff_speed;
    status_word[pcp_pkg::PCP_ST_LOWPWR_BIT] = eff_lowpwr;
    status_word[pcp_pkg::PCP_ST_LOCK_BIT] = lock_q;
    status_word[pcp_pkg::PCP_ST_LINK_BIT] = link_q;
    status_word[pcp_pkg::PCP_ST_SIGDET_BIT] = sigdet_q;
    status_word[pcp_pkg::PCP_ST_RUN_BIT] = running;
  end

  // unmapped address reads zero with slave error
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    if (s_axi_araddr == pcp_pkg::PCP_OFF_CTRL) begin
      rd_word[1:0] = ctrl_q;
    end else if (s_axi_araddr == pcp_pkg::PCP_OFF_STATUS) begin
      rd_word = status_word;
    end else if (s_axi_araddr == pcp_pkg::PCP_OFF_INT_STAT) begin
      rd_word[pcp_pkg::PCP_INT_W-1:0] = int_stat_q;
    end else if (s_axi_araddr == pcp_pkg::PCP_OFF_INT_MASK) begin
      rd_word[pcp_pkg::PCP_INT_W-1:0] = int_mask_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pcp_pkg::PCP_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? pcp_pkg::PCP_RESP_OKAY
                             : pcp_pkg::PCP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: tb/pcp_board_model.sv
// board side of the two-way config pins: strap resistors plus device drive
// assumes straps are set by the bench as pull-up or pull-down levels
`timescale 1ns/1ps
module pcp_board_model (
  input wire logic speed_strap,
  input wire logic low_power_strap,
  input wire logic speed_select_out,
  input wire logic speed_select_oe,
  input wire logic low_power_ten_select_out,
  input wire logic low_power_ten_select_oe,
  output logic speed_pin,
  output logic low_power_pin
);
  // pin level: device drive wins over the strap resistor
  assign speed_pin = speed_select_oe ?
    speed_select_out : speed_strap;
  assign low_power_pin = low_power_ten_select_oe ?
    low_power_ten_select_out : low_power_strap;
  // reserved reference output is not modelled, never driven
endmodule

// file: tb/pcp_checker.sv
// assertions on the pin side of pcp_config_status
// assumes straps stay steady while the core runs
`timescale 1ns/1ps
module pcp_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic hard_reset_low,
  input wire logic descrambler_locked,
  input wire logic link_established,
  input wire logic signal_detected,
  input wire logic rx_activity,
  input wire logic tx_activity,
  input wire logic cipher_lock_out,
  input wire logic link_up_out,
  input wire logic carrier_sense_out,
  input wire logic core_reset,
  input wire logic [1:0] iface_mode,
  input wire logic speed_select_oe,
  input wire logic low_power_ten_select_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // -----------------------------------------------------------------
  // status pins
  // -----------------------------------------------------------------
  a_lock_high: assert property (
    ce && !core_reset && descrambler_locked |=> cipher_lock_out)
    else $error("lock pin low while locked");
  a_lock_low: assert property (
    ce && (core_reset || !descrambler_locked) |=> !cipher_lock_out)
    else $error("lock pin high without lock");
  // iface_mode and link pin both register the same cycle's decode
  a_link_mii: assert property (
    ce && !core_reset
    |=> iface_mode != pcp_pkg::PCP_IF_MII
        || link_up_out == $past(link_established))
    else $error("link pin wrong in mii mode");
  a_link_stream: assert property (
    ce && !core_reset
    |=> iface_mode == pcp_pkg::PCP_IF_MII
        || link_up_out == $past(signal_detected))
    else $error("signal detect pin wrong in stream mode");
  a_carrier_rx: assert property (
    ce && !core_reset && rx_activity |=> carrier_sense_out)
    else $error("carrier sense missing on receive");
  a_carrier_idle: assert property (
    ce && !rx_activity && !tx_activity |=> !carrier_sense_out)
    else $error("carrier sense without activity");
  a_oe_sw_pair: assert property (
    speed_select_oe |-> low_power_ten_select_oe && !$past(core_reset))
    else $error("pin drive enables disagree");
  a_core_hold: assert property (
    (ce && !hard_reset_low) [*5] |-> core_reset)
    else $error("core runs while reset pin low");
  a_core_run: assert property (
    (ce && hard_reset_low) [*8] |-> !core_reset)
    else $error("core held after reset pin high");
  // main scenarios
  c_serial: cover property (!core_reset && iface_mode == 2'h2);
  c_drive: cover property (speed_select_oe);
  c_repeat: cover property (!core_reset && tx_activity && !rx_activity);
endmodule
bind pcp_config_status pcp_checker chk_i (.*);

// file: tb/tb_pcp_config_status.sv
// self-checking bench for pcp_config_status
// assumes a 40 MHz clock and the register map of pcp_pkg
`timescale 1ns/1ps
module tb_pcp_config_status;
  logic clk, reset, ce, hard_reset_low, control_source_select;
  logic station_role_select, mii_stream_select, speed_select_in;
  logic speed_select_out, speed_select_oe, low_power_ten_select_in;
  logic low_power_ten_select_out, low_power_ten_select_oe, irq;
  logic cipher_lock_out, link_up_out, carrier_sense_out, core_reset;
  logic descrambler_locked, link_established, signal_detected;
  logic rx_activity, tx_activity, sqe_test_enable, speed_100;
  logic [1:0] iface_mode, s_axi_bresp, s_axi_rresp;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, spd_strap, lp_strap;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [4:0] cfg [5] = '{5'h03, 5'h0e, 5'h04, 5'h07, 5'h02};
  logic [1:0] exp_if [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
  pcp_config_status #(.ADDR_W(5)) dut (.*);
  pcp_board_model board (
    .speed_strap(spd_strap),
    .low_power_strap(lp_strap),
    .speed_select_out(speed_select_out),
    .speed_select_oe(speed_select_oe),
    .low_power_ten_select_out(low_power_ten_select_out),
    .low_power_ten_select_oe(low_power_ten_select_oe),
    .speed_pin(speed_select_in),
    .low_power_pin(low_power_ten_select_in)
  );
  // -----------------------------------------------------------------
  // reference clock and hang guard
  // -----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  // one write: address and data offered together, bready held high
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {1'b0, a};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_bvalid) begin
        chk("bresp", 32'h0, {30'h0, s_axi_bresp});
        break;
      end
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask
  // one read, compared with expected data and response
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ar;
    ar = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (ar && s_axi_rvalid) begin
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        break;
      end
      if (!ar && s_axi_arready) begin
        ar = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask
  // pin reset, new straps, release and let the core start
  task automatic boot(input logic [4:0] s);
    hard_reset_low <= 1'b0;
    {control_source_select, station_role_select, mii_stream_select,
     spd_strap, lp_strap} <= s;
    repeat (6) @(posedge clk);
    chk("core_reset", 32'h1, {31'h0, core_reset});
    hard_reset_low <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    hard_reset_low = 1'b0;
    {control_source_select, station_role_select, mii_stream_select} = 3'h0;
    {spd_strap, lp_strap, descrambler_locked, link_established} = 4'h0;
    {signal_detected, rx_activity, tx_activity} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    // hardware-mode strap table: interface, speed and role decode
    for (int i = 0; i < 5; i++) begin
      boot(cfg[i]);
      chk("iface", {30'h0, exp_if[i]}, {30'h0, iface_mode});
      chk("sqe", {31'h0, !cfg[i][3]}, {31'h0, sqe_test_enable});
      chk("speed_100", {31'h0, cfg[i][1]}, {31'h0, speed_100});
      chk("speed_oe", 32'h0, {31'h0, speed_select_oe});
    end
    rd({1'b0, pcp_pkg::PCP_OFF_CTRL}, 32'h1, pcp_pkg::PCP_RESP_OKAY);
    rd({1'b0, pcp_pkg::PCP_OFF_STATUS}, 32'h210, 2'h0);
    rd(5'h10, 32'h0, pcp_pkg::PCP_RESP_SLVERR);
    // lock event, masked then unmasked interrupt, clear
    wr(pcp_pkg::PCP_OFF_INT_STAT, 32'h7);
    wr(pcp_pkg::PCP_OFF_INT_MASK, 32'h0);
    descrambler_locked <= 1'b1;
    repeat (3) @(posedge clk);
    chk("lock_out", 32'h1, {31'h0, cipher_lock_out});
    chk("irq", 32'h0, {31'h0, irq});
    rd({1'b0, pcp_pkg::PCP_OFF_INT_STAT}, 32'h1, 2'h0);
    wr(pcp_pkg::PCP_OFF_INT_MASK, 32'h1);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(pcp_pkg::PCP_OFF_INT_STAT, 32'h1);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // link and carrier sense as a node on mii
    {descrambler_locked, link_established, tx_activity} <= 3'h3;
    repeat (3) @(posedge clk);
    chk("lock_out", 32'h0, {31'h0, cipher_lock_out});
    chk("link_out", 32'h1, {31'h0, link_up_out});
    chk("carrier", 32'h1, {31'h0, carrier_sense_out});
    // software mode, repeater, stream interface
    boot(5'h1c);
    signal_detected <= 1'b1;
    link_established <= 1'b0;
    repeat (3) @(posedge clk);
    chk("iface_mode", 32'h1, {30'h0, iface_mode});
    chk("speed_pin", 32'h1, {31'h0, speed_select_in});
    chk("carrier", 32'h0, {31'h0, carrier_sense_out});
    chk("sigdet_out", 32'h1, {31'h0, link_up_out});
    rd({1'b0, pcp_pkg::PCP_OFF_STATUS}, 32'h317, 2'h0);
    rx_activity <= 1'b1;
    wr(pcp_pkg::PCP_OFF_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    chk("speed_out", 32'h0, {31'h0, speed_select_out});
    chk("lp_pin", 32'h1, {31'h0, low_power_ten_select_in});
    chk("carrier", 32'h1, {31'h0, carrier_sense_out});
    // clock enable low freezes the core against the pin reset
    ce <= 1'b0;
    hard_reset_low <= 1'b0;
    repeat (6) @(posedge clk);
    chk("core_frozen", 32'h0, {31'h0, core_reset});
    // pin reset in mid-run drops the outputs
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk("core_reset", 32'h1, {31'h0, core_reset});
    chk("sigdet_out", 32'h0, {31'h0, link_up_out});
    final_report();
  end
endmodule
